// File: bulk_list_pkg.sv
// Purpose: Shared constants and types for the bulk list pointer registers
// Assumes: Byte offsets from the controller's operational base address
// Notes: Pointers are 16-byte aligned; the low nibble is always zero
package bulk_list_pkg;

   // Register window
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] BULK_HEAD_OFS = 8'h28;
   localparam logic [ADDR_W-1:0] BULK_CURRENT_OFS = 8'h2C;

   // Field layout of both pointer registers
   localparam int PTR_LSB = 4;
   localparam int PTR_W = 28;
   localparam logic [PTR_LSB-1:0] PTR_RSVD_VALUE = 4'h0;
   localparam logic [DATA_W-1:0] PTR_RESET = 32'h00000000;
   localparam logic [DATA_W-1:0] READ_UNMAPPED = 32'h00000000;

   // Pointer value that marks the end of the list
   localparam logic [DATA_W-1:0] LIST_END_PTR = 32'h00000000;

   typedef enum logic [2:0]
   {
      st_idle = 3'b001,
      st_fetch = 3'b010,
      st_end = 3'b100
   } walk_state_e;

   function automatic logic reg_hit
   (
      input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] ofs
   );
      return addr == ofs;
   endfunction : reg_hit

endpackage : bulk_list_pkg

// File: bulk_ptr_reg.sv
// Purpose: One 16-byte aligned pointer register with software and
//          hardware write ports
// Assumes: Hardware and software loads are never wanted in one cycle;
//          if they meet, the hardware load wins
// Notes: Low nibble is held at zero whatever is written
`timescale 1ns/100ps
`default_nettype none

module bulk_ptr_reg
   import bulk_list_pkg::*;
#(
   parameter int WIDTH = PTR_W
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sw_we,
   input wire logic [DATA_W-1:0] sw_data,
   input wire logic hw_we,
   input wire logic [DATA_W-1:0] hw_data,
   output logic [DATA_W-1:0] value
);

   logic [WIDTH-1:0] field;
   logic [WIDTH-1:0] next_field;

   // Only the address bits are kept; the low bits are not stored
   assign next_field = hw_we ? hw_data[DATA_W-1:PTR_LSB]
                             : sw_data[DATA_W-1:PTR_LSB];

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         field <= PTR_RESET[DATA_W-1:PTR_LSB];
      end
      else if (hw_we || sw_we)
      begin
         field <= next_field;
      end
   end

   assign value = {field, PTR_RSVD_VALUE};

endmodule : bulk_ptr_reg

`default_nettype wire

// File: bulk_list_pointer_regs.sv
// Purpose: Bulk list head and current endpoint pointers, with the
//          round-robin walk that advances and reloads the current one
// Assumes: The descriptor engine fetches and serves one endpoint
//          descriptor per request and returns its next-link field
// Notes: Register reads answer one cycle after the read strobe
//
// Notes on behaviour
// - Head pointer register lives at offset 28h
// - Pointer in bits 31:4, low nibble zero, resets zero
// - Each bulk traversal starts from the head pointer
// - Head loaded from shared area during initialisation
// - Current pointer register lives at offset 2Ch
// - Endpoints served round-robin in list order
// - Current advances to next descriptor after service
// - New frame resumes where previous frame stopped
// - At list end, filled flag reloads and clears
// - Current pointer starts at zero, meaning end
`timescale 1ns/100ps
`default_nettype none

module bulk_list_pointer_regs
(
   input wire logic clk,
   input wire logic rst_n,

   // Register access from the driver, decoded from the base address
   input wire logic [bulk_list_pkg::ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [bulk_list_pkg::DATA_W-1:0] reg_wdata,
   output logic [bulk_list_pkg::DATA_W-1:0] reg_rdata,
   output logic reg_rvalid,

   // Controller initialisation
   input wire logic init_load,
   input wire logic [bulk_list_pkg::DATA_W-1:0] shared_communication_area_head_addr,

   // Control and command status bits kept elsewhere
   input wire logic bulk_list_enable,
   input wire logic list_filled_flag,
   output logic list_filled_clear,

   // Frame scheduler
   input wire logic frame_start,
   input wire logic bulk_slot,

   // Descriptor engine
   output logic desc_fetch_valid,
   output logic [bulk_list_pkg::DATA_W-1:0] desc_fetch_addr,
   input wire logic desc_done,
   input wire logic [bulk_list_pkg::DATA_W-1:0] next_desc_addr,

   // Walk status
   output logic list_busy,
   output logic list_end_seen
);

   import bulk_list_pkg::*;

   walk_state_e state;
   walk_state_e next_state;

   logic [DATA_W-1:0] head_value;
   logic [DATA_W-1:0] cur_value;
   logic [DATA_W-1:0] next_rdata;
   logic [DATA_W-1:0] cur_hw_data;

   wire head_hit;
   wire cur_hit;
   wire head_sw_we;
   wire cur_sw_we;
   wire cur_hw_we;
   wire cur_is_end;
   wire next_is_end;
   wire in_idle;
   wire in_fetch;
   wire in_end;
   wire start_walk;
   wire advance;
   wire reload;
   wire fetch_abort;

   // Register decode

   assign head_hit = reg_hit(reg_addr, BULK_HEAD_OFS);
   assign cur_hit = reg_hit(reg_addr, BULK_CURRENT_OFS);

   assign head_sw_we = reg_wr & head_hit;

   // A write to the current pointer while bulk_list_enable is set is dropped,
   // so the list engine never sees a pointer change under its feet
   assign cur_sw_we = reg_wr & cur_hit & ~bulk_list_enable;

   // Walk state decode

   assign in_idle = (state == st_idle);
   assign in_fetch = (state == st_fetch);
   assign in_end = (state == st_end);

   assign cur_is_end = (cur_value == LIST_END_PTR);
   assign next_is_end = (next_desc_addr[DATA_W-1:PTR_LSB] ==
                         LIST_END_PTR[DATA_W-1:PTR_LSB]);

   // A bulk slot starts one descriptor service from the saved pointer
   assign start_walk = in_idle & bulk_list_enable & bulk_slot;

   // Follow the next link of the served descriptor
   assign advance = in_fetch & desc_done;

   // List end with the filled flag set rewinds to the head
   assign reload = in_end & list_filled_flag;

   // Frame boundary or disable drops the request, pointer untouched
   assign fetch_abort = in_fetch & ~desc_done &
                        (frame_start | ~bulk_list_enable);

   assign cur_hw_we = advance | reload;

   always_comb
   begin
      cur_hw_data = head_value;
      if (advance)
      begin
         cur_hw_data = next_desc_addr;
      end
   end

   // Pointer registers

   bulk_ptr_reg #(
      .WIDTH(PTR_W)
   ) head_reg (
      .clk(clk),
      .rst_n(rst_n),
      .sw_we(head_sw_we),
      .sw_data(reg_wdata),
      .hw_we(init_load),
      .hw_data(shared_communication_area_head_addr),
      .value(head_value)
   );

   bulk_ptr_reg #(
      .WIDTH(PTR_W)
   ) current_reg (
      .clk(clk),
      .rst_n(rst_n),
      .sw_we(cur_sw_we),
      .sw_data(reg_wdata),
      .hw_we(cur_hw_we),
      .hw_data(cur_hw_data),
      .value(cur_value)
   );

   // Walk state machine

   always_comb
   begin
      next_state = state;
      unique case (state)
         st_idle:
         begin
            if (start_walk)
            begin
               // Nothing is fetched from a zero pointer
               if (cur_is_end)
               begin
                  next_state = st_end;
               end
               else
               begin
                  next_state = st_fetch;
               end
            end
         end
         st_fetch:
         begin
            if (advance)
            begin
               if (next_is_end)
               begin
                  next_state = st_end;
               end
               else
               begin
                  next_state = st_idle;
               end
            end
            else if (fetch_abort)
            begin
               next_state = st_idle;
            end
         end
         st_end:
         begin
            next_state = st_idle;
         end
         default:
         begin
            next_state = st_idle;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= st_idle;
      end
      else
      begin
         state <= next_state;
      end
   end

   // Walk outputs

   // Request stands until the engine reports the descriptor done, or a frame start or disable aborts it
   assign desc_fetch_valid = in_fetch & ~cur_is_end;
   assign desc_fetch_addr = cur_value;

   // Clear strobe to the command status flag, one cycle
   assign list_filled_clear = reload;

   assign list_busy = ~in_idle;
   assign list_end_seen = in_end;

   // Register read path

   always_comb
   begin
      next_rdata = READ_UNMAPPED;
      if (head_hit)
      begin
         next_rdata = head_value;
      end
      else if (cur_hit)
      begin
         // Instantaneous value, also while the walk is running
         next_rdata = cur_value;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_rdata <= PTR_RESET;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_rd;
         if (reg_rd)
         begin
            reg_rdata <= next_rdata;
         end
      end
   end

endmodule : bulk_list_pointer_regs

`default_nettype wire

// File: bulk_ptr_chk_properties.sv
// Purpose: Port assertions for the bulk pointer block
// Assumes: One clock domain, async active-low reset
// Notes: Bound to every instance of the block
`timescale 1ns/100ps
`default_nettype none
module bulk_ptr_chk
   import bulk_list_pkg::*;
(
   input wire logic clk, rst_n, reg_rd, reg_wr, reg_rvalid, desc_done,
   input wire logic bulk_list_enable, list_filled_flag, list_filled_clear,
   input wire logic frame_start, bulk_slot, desc_fetch_valid, list_busy,
   input wire logic list_end_seen,
   input wire logic [DATA_W-1:0] reg_rdata, desc_fetch_addr, next_desc_addr
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_start;
      !list_busy && bulk_list_enable && bulk_slot && !frame_start;
   endsequence
   sequence s_end_fill;
      list_end_seen && list_filled_flag;
   endsequence
   AST_RD_LAT: assert property (reg_rvalid == $past(reg_rd))
      else $error("read answer late");
   AST_LOW_NIBBLE: assert property (desc_fetch_addr[3:0] == 4'h0)
      else $error("pointer low bits set");
   AST_NO_ZERO_FETCH: assert property (desc_fetch_valid |->
      desc_fetch_addr != LIST_END_PTR) else $error("fetch from zero");
   AST_START: assert property (s_start ##1 (bulk_list_enable &&
      !frame_start && desc_fetch_addr != 0) |-> desc_fetch_valid)
      else $error("no fetch after slot");
   AST_ADVANCE: assert property (desc_fetch_valid && desc_done &&
      !frame_start |=> desc_fetch_addr == $past(next_desc_addr))
      else $error("pointer not advanced");
   AST_HOLD: assert property (desc_fetch_valid && !desc_done &&
      !frame_start && bulk_list_enable |=> desc_fetch_valid &&
      $stable(desc_fetch_addr)) else $error("fetch dropped");
   AST_FILL_CLR: assert property (s_end_fill |-> list_filled_clear)
      else $error("flag not cleared");
   AST_CLR_CAUSE: assert property (list_filled_clear |->
      list_end_seen && list_filled_flag) else $error("stray clear");
   AST_NO_FILL: assert property (list_end_seen && !list_filled_flag &&
      !reg_wr |=> $stable(desc_fetch_addr)) else $error("reload unasked");
endmodule : bulk_ptr_chk
bind bulk_list_pointer_regs bulk_ptr_chk bulk_ptr_chk_inst (.clk, .rst_n,
   .reg_rd, .reg_wr, .reg_rvalid, .desc_done, .bulk_list_enable,
   .list_filled_flag, .list_filled_clear, .frame_start, .bulk_slot,
   .desc_fetch_valid, .list_busy, .list_end_seen, .reg_rdata,
   .desc_fetch_addr, .next_desc_addr);
`default_nettype wire

// File: bulk_desc_engine.sv
// Purpose: Descriptor engine model serving one fetch per request
// Assumes: Descriptors are linked 16 bytes apart up to LAST_ADDR
// Notes: Slow mode answers on the fifth cycle of the request
`timescale 1ns/100ps
`default_nettype none
module bulk_desc_engine
   import bulk_list_pkg::*;
#(parameter logic [DATA_W-1:0] LAST_ADDR = 32'h00001000)
(
   input wire logic clk, rst_n, slow, desc_fetch_valid,
   input wire logic [DATA_W-1:0] desc_fetch_addr,
   output logic desc_done,
   output logic [DATA_W-1:0] next_desc_addr
);
   logic [1:0] cnt;
   logic [DATA_W-1:0] link;
   // Last descriptor links to the list end
   assign link = (desc_fetch_addr >= LAST_ADDR) ? LIST_END_PTR
      : desc_fetch_addr + 32'h10;
   // Junk outside the done cycle
   assign next_desc_addr = desc_done ? link : ~link;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt <= 2'h0;
      else
         cnt <= (desc_fetch_valid && !desc_done) ? cnt + 2'h1 : 2'h0;
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         desc_done <= 1'b0;
      else
         desc_done <= desc_fetch_valid && !desc_done &&
            (!slow || cnt == 2'h3);
   end
endmodule : bulk_desc_engine
`default_nettype wire

// File: tb_top.sv
// Purpose: Self-checking bench for the bulk pointer registers
// Assumes: Bench acts as driver software and command status logic
// Notes: Random heads from a fixed seed
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) chk(n, e, s)
module tb_top;
   import bulk_list_pkg::*;
   localparam logic [31:0] LAST = 32'h00001000;
   logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, init_load = 0;
   logic bulk_list_enable = 0, list_filled_flag = 0, frame_start = 0;
   logic bulk_slot = 0, slow = 0, reg_rvalid, list_filled_clear, e;
   logic desc_fetch_valid, desc_done, list_busy, list_end_seen;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, shared_communication_area_head_addr = 32'h0, reg_rdata;
   logic [31:0] desc_fetch_addr, next_desc_addr, d, h, x;
   int failures = 0, tests_run = 0, seed = 86239, k;
   always #4 clk = ~clk;
   always @(posedge clk) if (list_filled_clear === 1'b1) list_filled_flag <= 0;
   bulk_list_pointer_regs bulk_list_pointer_regs_inst (.clk, .rst_n,
      .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
      .init_load, .shared_communication_area_head_addr, .bulk_list_enable, .list_filled_flag,
      .list_filled_clear, .frame_start, .bulk_slot, .desc_fetch_valid,
      .desc_fetch_addr, .desc_done, .next_desc_addr, .list_busy,
      .list_end_seen);
   bulk_desc_engine #(.LAST_ADDR(LAST)) bulk_desc_engine_inst (.clk,
      .rst_n, .slow, .desc_fetch_valid, .desc_fetch_addr, .desc_done,
      .next_desc_addr);
   function automatic logic [31:0] masked(input logic [31:0] v);
      return {v[31:4], PTR_RSVD_VALUE};
   endfunction : masked
   task stop_test;
      if (failures == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : stop_test
   task tmo;
      failures++;
      stop_test;
   endtask : tmo
   task chk(input string n, input logic [31:0] ex, input logic [31:0] s);
      tests_run++;
      if (s !== ex)
      begin
         failures++;
         $display("[ERR] %s exp %h got %h", n, ex, s);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, output logic [31:0] v);
      int i;
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) @(posedge clk) #1;
      if (i == 4) tmo;
      v = reg_rdata;
   endtask : rd
   task slot(output logic [31:0] a, output logic en);
      int i;
      @(posedge clk);
      bulk_slot <= 1'b1;
      @(posedge clk);
      bulk_slot <= 1'b0;
      #1;
      for (i = 0; i < 8 && desc_fetch_valid !== 1 && list_end_seen !== 1;
         i++) @(posedge clk) #1;
      if (i == 8) tmo;
      en = list_end_seen;
      a = desc_fetch_addr;
      `CHK("busy", 1'b1, list_busy);
      for (i = 0; i < 8 && list_busy !== 1'b0; i++) @(posedge clk) #1;
      if (i == 8) tmo;
   endtask : slot
   initial
   begin
      #800000;
      tmo;
   end
   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rd(BULK_HEAD_OFS, d);
      `CHK("head_rst", PTR_RESET, d);
      rd(BULK_CURRENT_OFS, d);
      `CHK("cur_rst", LIST_END_PTR, d);
      rd(8'h30, d);
      `CHK("unmapped", READ_UNMAPPED, d);
      repeat (4)
      begin
         h = $random(seed);
         wr(BULK_HEAD_OFS, masked(h));
         rd(BULK_HEAD_OFS, d);
         `CHK("head_rw", masked(h), d);
         wr(BULK_CURRENT_OFS, masked(~h));
         rd(BULK_CURRENT_OFS, d);
         `CHK("cur_rw", masked(~h), d);
      end
      @(posedge clk);
      bulk_list_enable <= 1'b1;
      wr(BULK_CURRENT_OFS, masked(h));
      rd(BULK_CURRENT_OFS, d);
      `CHK("cur_locked", masked(~h), d);
      @(posedge clk);
      shared_communication_area_head_addr <= $random(seed);
      init_load <= 1'b1;
      @(posedge clk);
      init_load <= 1'b0;
      rd(BULK_HEAD_OFS, d);
      `CHK("head_init", masked(shared_communication_area_head_addr), d);
      @(posedge clk);
      bulk_list_enable <= 1'b0;
      wr(BULK_CURRENT_OFS, 32'h0);
      k = {$random(seed)} % 4;
      h = LAST - 32'h10 * k;
      wr(BULK_HEAD_OFS, h);
      @(posedge clk);
      bulk_list_enable <= 1'b1;
      list_filled_flag <= 1'b1;
      slot(x, e);
      `CHK("end_empty", 1'b1, e);
      `CHK("flag_clear", 1'b0, list_filled_flag);
      for (int i = 0; i <= k; i++)
      begin
         slot(x, e);
         `CHK("walk", h + 32'h10 * i, x);
      end
      rd(BULK_CURRENT_OFS, d);
      `CHK("no_reload", LIST_END_PTR, d);
      @(posedge clk);
      list_filled_flag <= 1'b1;
      slot(x, e);
      rd(BULK_CURRENT_OFS, d);
      `CHK("reload", h, d);
      @(posedge clk);
      slow <= 1'b1;
      bulk_slot <= 1'b1;
      @(posedge clk);
      bulk_slot <= 1'b0;
      @(posedge clk);
      frame_start <= 1'b1;
      @(posedge clk);
      frame_start <= 1'b0;
      slow <= 1'b0;
      #1;
      `CHK("abort", 1'b0, desc_fetch_valid);
      slot(x, e);
      `CHK("resume", h, x);
      stop_test;
   end
endmodule : tb_top
`default_nettype wire
